// File: rtl/des_engine.sv
// Six-channel transfer engine with event synchronisation and idle control.
// Assumes event and wake inputs come from other clock domains or pins;
// memory ports answer with a one-cycle ack on the system clock.
`timescale 1ns/1ps
`default_nettype none
module des_engine
    import des_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Channel programming
    input wire logic [NUM_CH-1:0] cfg_we,
    input wire logic [SEL_W-1:0] cfg_sel,
    input wire logic cfg_prio_hi,
    input wire logic [1:0] cfg_src_port,
    input wire logic [1:0] cfg_dst_port,
    input wire logic [1:0] cfg_src_mod,
    input wire logic [1:0] cfg_dst_mod,
    input wire logic [ADDR_W-1:0] cfg_src_addr,
    input wire logic [ADDR_W-1:0] cfg_dst_addr,
    input wire logic [ADDR_W-1:0] cfg_count,
    input wire logic [NUM_CH-1:0] ch_enable,
    // Idle control
    input wire logic idle_req,
    input wire logic serial_wake,
    // Synchronisation events
    input wire logic [NUM_EVT-1:0] evt_in,
    // Shared memory port
    output logic [NUM_PORT-1:0] mem_req,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [DATA_W-1:0] mem_rdata,
    // Status
    output logic [NUM_CH-1:0] ch_irq,
    output logic [NUM_CH-1:0] ch_busy,
    output logic idle_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} des_xfer_t;

    typedef struct packed {
        logic [NUM_CH-1:0][SEL_W-1:0] sel;
        logic [NUM_CH-1:0] prio;
        logic [NUM_CH-1:0][1:0] sport;
        logic [NUM_CH-1:0][1:0] dport;
        logic [NUM_CH-1:0][1:0] smod;
        logic [NUM_CH-1:0][1:0] dmod;
        logic [NUM_CH-1:0][ADDR_W-1:0] saddr;
        logic [NUM_CH-1:0][ADDR_W-1:0] daddr;
        logic [NUM_CH-1:0][ADDR_W-1:0] cnt;
        logic [NUM_CH-1:0] pend;
        logic [NUM_CH-1:0] busy;
        logic [NUM_CH-1:0] irq;
        logic [NUM_EVT-1:0] ev_s1;
        logic [NUM_EVT-1:0] ev_s2;
        logic [NUM_EVT-1:0] ev_s3;
        logic [2:0] wk_s;
        logic sw_idle;
        logic idle;
        logic auto_wake;
        des_xfer_t st;
        logic [2:0] cur;
        logic [DATA_W-1:0] buf_d;
        logic [NUM_PORT-1:0] req;
        logic we;
        logic [ADDR_W-1:0] addr;
    } des_state_t;

    des_state_t s_q;
    des_state_t s_d;

    // Maps a selector code to its event bit; reserved codes yield none
    function automatic logic sel_hit(input logic [4:0] sel, input logic [NUM_EVT-1:0] ev);
        logic r;
        r = 1'b0;
        case (sel)
            SEL_S0_RX: r = ev[EV_S0_RX];
            SEL_S0_TX: r = ev[EV_S0_TX];
            SEL_S1_RX: r = ev[EV_S1_RX];
            SEL_S1_TX: r = ev[EV_S1_TX];
            SEL_ASYNC_RX: r = ev[EV_ASYNC_RX];
            SEL_ASYNC_TX: r = ev[EV_ASYNC_TX];
            SEL_TIM0, SEL_TIM1: r = ev[EV_TIM0 + int'(sel - SEL_TIM0)];
            SEL_TWB_RX: r = ev[EV_TWB_RX];
            SEL_TWB_TX: r = ev[EV_TWB_TX];
            default:
            begin
                // External interrupts occupy a contiguous code range
                if (sel >= SEL_XINT0 && sel <= SEL_XINT3)
                begin
                    r = ev[EV_XINT0 + int'(sel - SEL_XINT0)];
                end
            end
        endcase
        return r;
    endfunction

    // Address stepping, used for both source and destination
    function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a, input logic [1:0] m);
        logic [ADDR_W-1:0] r;
        r = a;
        case (m)
            AMOD_INC: r = a + 16'h0001;
            AMOD_DEC: r = a - 16'h0001;
            default: r = a;
        endcase
        return r;
    endfunction

    logic [NUM_EVT-1:0] ev_rise;
    logic [NUM_CH-1:0] ready;
    logic [2:0] pick;
    logic pick_ok;
    logic active;
    logic wake_rise;

    // Event and wake edges taken after the two-stage synchronisers
    assign ev_rise = s_q.ev_s2 & ~s_q.ev_s3;
    assign wake_rise = s_q.wk_s[1] && !s_q.wk_s[2]; // A held wake line must not re-wake
    assign active = !s_q.sw_idle || s_q.auto_wake;

    // Arbiter: high-priority ready channels first, lowest index within a level
    always_comb
    begin
        pick = 3'h0;
        pick_ok = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            ready[i] = s_q.busy[i] && (s_q.sel[i] == SEL_NONE || s_q.pend[i]);
        end
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (ready[i] && !s_q.prio[i])
            begin
                pick = 3'(i);
                pick_ok = 1'b1;
            end
        end
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (ready[i] && s_q.prio[i])
            begin
                pick = 3'(i);
                pick_ok = 1'b1;
            end
        end
    end

    // Next-state logic for all channels and the transfer sequencer
    always_comb
    begin
        s_d = s_q;
        s_d.ev_s1 = evt_in;
        s_d.ev_s2 = s_q.ev_s1;
        s_d.ev_s3 = s_q.ev_s2;
        s_d.wk_s = {s_q.wk_s[1:0], serial_wake};
        s_d.sw_idle = idle_req;
        s_d.irq = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            // Programming touches only the written channel
            if (cfg_we[c] && !s_q.busy[c])
            begin
                s_d.sel[c] = cfg_sel;
                s_d.prio[c] = cfg_prio_hi;
                s_d.sport[c] = cfg_src_port;
                s_d.dport[c] = cfg_dst_port;
                s_d.smod[c] = cfg_src_mod;
                s_d.dmod[c] = cfg_dst_mod;
                s_d.saddr[c] = cfg_src_addr;
                s_d.daddr[c] = cfg_dst_addr;
                s_d.cnt[c] = cfg_count;
            end
            if (ch_enable[c] && !s_q.busy[c] && s_q.cnt[c] != '0)
            begin
                s_d.busy[c] = 1'b1;
                s_d.pend[c] = 1'b0;
            end
            // Each channel watches its own selected event
            if (s_q.busy[c] && sel_hit(s_q.sel[c], ev_rise))
            begin
                s_d.pend[c] = 1'b1;
            end
        end
        case (s_q.st)
            ST_IDLE:
            begin
                if (pick_ok && active)
                begin
                    s_d.cur = pick;
                    s_d.st = ST_READ;
                    s_d.req = '0;
                    s_d.req[s_q.sport[pick]] = 1'b1;
                    s_d.we = 1'b0;
                    s_d.addr = s_q.saddr[pick];
                end
            end
            ST_READ:
            begin
                if (mem_ack)
                begin
                    s_d.buf_d = mem_rdata;
                    s_d.st = ST_WRITE;
                    s_d.req = '0;
                    s_d.req[s_q.dport[s_q.cur]] = 1'b1;
                    s_d.we = 1'b1;
                    s_d.addr = s_q.daddr[s_q.cur];
                end
            end
            ST_WRITE:
            begin
                if (mem_ack)
                begin
                    s_d.req = '0;
                    s_d.we = 1'b0;
                    s_d.st = ST_IDLE;
                    s_d.saddr[s_q.cur] = step(s_q.saddr[s_q.cur], s_q.smod[s_q.cur]);
                    s_d.daddr[s_q.cur] = step(s_q.daddr[s_q.cur], s_q.dmod[s_q.cur]);
                    s_d.cnt[s_q.cur] = s_q.cnt[s_q.cur] - 16'h0001;
                    s_d.pend[s_q.cur] = sel_hit(s_q.sel[s_q.cur], ev_rise);
                    if (s_q.cnt[s_q.cur] == 16'h0001)
                    begin
                        s_d.busy[s_q.cur] = 1'b0;
                        s_d.irq[s_q.cur] = 1'b1;
                        s_d.auto_wake = 1'b0;
                    end
                end
            end
            default:
            begin
                s_d.st = ST_IDLE;
                s_d.req = '0;
            end
        endcase
        // Wake is applied after completion so a wake edge in that cycle wins
        if (!idle_req)
        begin
            s_d.auto_wake = 1'b0;
        end
        else if (wake_rise && s_q.sw_idle)
        begin
            s_d.auto_wake = 1'b1;
        end
        s_d.idle = s_d.sw_idle && !s_d.auto_wake;
    end

    // State register; selectors clear to unsynchronised at reset
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            for (int c = 0; c < NUM_CH; c++)
            begin
                s_q.sel[c] <= SEL_RESET;
            end
            s_q.st <= ST_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from state flops
    assign mem_req = s_q.req;
    assign mem_we = s_q.we;
    assign mem_addr = s_q.addr;
    assign mem_wdata = s_q.buf_d;
    assign ch_irq = s_q.irq;
    assign ch_busy = s_q.busy;
    assign idle_out = s_q.idle;

    // Checks kept beside the logic
    a_sel_reset: assert property (@(posedge clk_sys) $rose(!rst) |-> s_q.sel == '0)
        else $error("selector not cleared after reset");
    a_idle_no_req: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.st == ST_IDLE && idle_out) |=> mem_req == '0)
        else $error("request issued while idle");
    a_one_port: assert property (@(posedge clk_sys) disable iff (rst)
        $onehot0(mem_req))
        else $error("more than one port requested");
    a_irq_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(ch_irq[0]) |-> $fell(ch_busy[0]))
        else $error("irq without channel completion");
    a_wake_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (idle_req && s_q.sw_idle && wake_rise) |=> !idle_out)
        else $error("serial wake ignored");
    a_auto_reidle: assert property (@(posedge clk_sys) disable iff (rst)
        (|ch_irq && idle_req && s_q.sw_idle && !$past(wake_rise)) |-> idle_out)
        else $error("no return to idle");
    a_src_step: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.st == ST_WRITE && mem_ack && s_q.smod[s_q.cur] == AMOD_INC && s_q.cur == 3'h0)
        |=> s_q.saddr[0] == $past(s_q.saddr[0]) + 16'h0001)
        else $error("source address not stepped");
    a_hi_first: assert property (@(posedge clk_sys) disable iff (rst)
        (pick_ok && !s_q.prio[pick]) |-> !(|(ready & s_q.prio)))
        else $error("low priority chosen over high");
    a_sync_wait: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.st == ST_IDLE && $changed(s_q.st) == 1'b0 && pick_ok)
        |-> (s_q.sel[pick] == SEL_NONE || s_q.pend[pick]))
        else $error("channel ran without its event");
endmodule // des_engine
`default_nettype wire

// File: rtl/des_pkg.sv
// Package for the six-channel event-synchronised transfer engine.
// Assumes a single 20 MHz system clock and no register bus.
package des_pkg;
    localparam int NUM_CH = 6;
    localparam int NUM_PORT = 4;
    localparam int SEL_W = 5;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int NUM_EVT = 14;
    // Port identifiers
    localparam logic [1:0] PORT_RAM0 = 2'h0;
    localparam logic [1:0] PORT_RAM1 = 2'h1;
    localparam logic [1:0] PORT_PERIPH = 2'h2;
    localparam logic [1:0] PORT_EXT = 2'h3;
    // Address modification modes
    localparam logic [1:0] AMOD_CONST = 2'h0;
    localparam logic [1:0] AMOD_INC = 2'h1;
    localparam logic [1:0] AMOD_DEC = 2'h2;
    // Event selector codes
    localparam logic [4:0] SEL_NONE = 5'h00;
    localparam logic [4:0] SEL_S0_RX = 5'h01;
    localparam logic [4:0] SEL_S0_TX = 5'h02;
    localparam logic [4:0] SEL_S1_RX = 5'h05;
    localparam logic [4:0] SEL_S1_TX = 5'h06;
    localparam logic [4:0] SEL_ASYNC_RX = 5'h0b;
    localparam logic [4:0] SEL_ASYNC_TX = 5'h0c;
    localparam logic [4:0] SEL_TIM0 = 5'h0d;
    localparam logic [4:0] SEL_TIM1 = 5'h0e;
    localparam logic [4:0] SEL_XINT0 = 5'h0f;
    localparam logic [4:0] SEL_XINT3 = 5'h12;
    localparam logic [4:0] SEL_TWB_RX = 5'h13;
    localparam logic [4:0] SEL_TWB_TX = 5'h14;
    // Event vector bit positions
    localparam int EV_S0_RX = 0;
    localparam int EV_S0_TX = 1;
    localparam int EV_S1_RX = 2;
    localparam int EV_S1_TX = 3;
    localparam int EV_ASYNC_RX = 4;
    localparam int EV_ASYNC_TX = 5;
    localparam int EV_TIM0 = 6;
    localparam int EV_XINT0 = 8;
    localparam int EV_TWB_RX = 12;
    localparam int EV_TWB_TX = 13;
    // Reset values
    localparam logic [4:0] SEL_RESET = 5'h00;
endpackage

// File: sim/des_mem_model.sv
// Memory-side partner: answers each port request with a one-cycle ack.
// Assumes one request at a time; lat sets the wait before the ack.
`timescale 1ns/1ps
`default_nettype none
module des_mem_model
    import des_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Engine side
    input wire logic [NUM_PORT-1:0] mem_req,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [3:0] lat,
    output logic mem_ack,
    output logic [DATA_W-1:0] mem_rdata
);
    logic [3:0] wait_q;
    // Read data is a pattern of address and port; idle bus toggles so stale data never matches
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mem_ack <= 1'b0;
            wait_q <= 4'h0;
            mem_rdata <= 16'hffff;
        end
        else if (mem_ack || mem_req == '0)
        begin
            mem_ack <= 1'b0;
            wait_q <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end
        else if (wait_q >= lat)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr ^ 16'ha5c3 ^ {12'h0, mem_req};
        end
        else
        begin
            wait_q <= wait_q + 4'h1;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // des_mem_model
`default_nettype wire

// File: sim/test_des_engine.sv
// Self-checking bench: the driver queues expected writes and interrupts,
// a watcher pops and compares them. Memory side is des_mem_model.
`timescale 1ns/1ps
`default_nettype none
module test_des_engine
    import des_pkg::*;
;
    logic clk_sys, rst, cfg_prio_hi, idle_req, serial_wake, mem_ack, mem_we, idle_out;
    logic [NUM_CH-1:0] cfg_we, ch_enable, ch_irq, ch_busy, e6;
    logic [SEL_W-1:0] cfg_sel;
    logic [1:0] cfg_src_port, cfg_dst_port, cfg_src_mod, cfg_dst_mod;
    logic [ADDR_W-1:0] cfg_src_addr, cfg_dst_addr, cfg_count, mem_addr;
    logic [DATA_W-1:0] mem_wdata, mem_rdata;
    logic [NUM_EVT-1:0] evt_in;
    logic [NUM_PORT-1:0] mem_req;
    logic [3:0] lat;
    logic [33:0] wr_q[$];
    logic [NUM_CH-1:0] irq_q[$];
    logic [33:0] e34;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 32'hbe4ebe08;
    logic [4:0] codes [NUM_EVT] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h0b, 5'h0c, 5'h0d,
        5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};

    des_engine des_engine_i (.clk_sys, .rst, .cfg_we, .cfg_sel, .cfg_prio_hi, .cfg_src_port,
        .cfg_dst_port, .cfg_src_mod, .cfg_dst_mod, .cfg_src_addr, .cfg_dst_addr, .cfg_count,
        .ch_enable, .idle_req, .serial_wake, .evt_in, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .ch_irq, .ch_busy, .idle_out);
    des_mem_model des_mem_model_i (.clk_sys, .rst, .mem_req, .mem_addr, .lat, .mem_ack,
        .mem_rdata);

    // Clock at 20 MHz, never stopped, which automatic wake relies on
    always #25 clk_sys = ~clk_sys;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_wr(input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch write exp=%h got=%h", e, g);
        end
    endtask

    task automatic chk_lvl(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s exp=%h got=%h", nm, e, g);
        end
    endtask

    // Inputs always move 2 ns after the rising edge
    task automatic tick();
        @(posedge clk_sys);
        #2;
    endtask

    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
        return (m == AMOD_INC) ? a + 16'h1 : (m == AMOD_DEC) ? a - 16'h1 : a;
    endfunction

    // Program one channel, optionally start it, and queue what it must produce
    task automatic prog(input int ch, input logic [4:0] sel, input logic hi,
        input logic [1:0] sp, dp, sm, dm, input logic [15:0] sa, da, cnt, input logic go);
        logic [15:0] s;
        logic [15:0] d;
        s = sa;
        d = da;
        {cfg_sel, cfg_prio_hi, cfg_src_port, cfg_dst_port} = {sel, hi, sp, dp};
        {cfg_src_mod, cfg_dst_mod, cfg_src_addr, cfg_dst_addr, cfg_count} = {sm, dm, sa, da, cnt};
        cfg_we = 6'(1 << ch);
        tick();
        cfg_we = '0;
        ch_enable[ch] = go;
        tick();
        ch_enable = '0;
        for (int i = 0; i < cnt; i++)
        begin
            wr_q.push_back({dp, d, s ^ 16'ha5c3 ^ (16'h1 << sp)});
            s = step(s, sm);
            d = step(d, dm);
        end
        irq_q.push_back(6'(1 << ch));
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while ((wr_q.size() != 0 || irq_q.size() != 0 || ch_busy !== '0) && n < 3000)
        begin
            tick();
            n++;
        end
        if (n >= 3000)
        begin
            fail_count++;
            $display("mismatch wait exp=done got=timeout");
            report_and_stop();
        end
    endtask

    // Watch that no port is requested for n cycles
    task automatic quiet(input int n);
        logic [3:0] seen;
        seen = '0;
        repeat (n)
        begin
            tick();
            seen |= mem_req;
        end
        chk_lvl("mem_req", 16'h0, {12'h0, seen});
    endtask

    task automatic pulse(input int b);
        evt_in[b] = 1'b1;
        repeat (3) tick();
        evt_in = '0;
        tick();
    endtask

    // Watcher: an unexpected result pops an unknown and so always mismatches
    always @(posedge clk_sys)
    begin
        if (!rst && mem_ack === 1'b1 && mem_we === 1'b1)
        begin
            e34 = wr_q.size() ? wr_q.pop_front() : 'x;
            chk_wr(e34, {mem_req[3] | mem_req[2], mem_req[3] | mem_req[1], mem_addr, mem_wdata});
        end
        if (!rst && ch_irq !== '0)
        begin
            e6 = irq_q.size() ? irq_q.pop_front() : 'x;
            chk_lvl("ch_irq", 16'(e6), 16'(ch_irq));
        end
    end

    initial
    begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {cfg_prio_hi, idle_req, serial_wake, cfg_we, ch_enable} = '0;
        {cfg_sel, cfg_src_port, cfg_dst_port, cfg_src_mod, cfg_dst_mod} = '0;
        {cfg_src_addr, cfg_dst_addr, cfg_count, evt_in, lat} = '0;
        repeat (2) tick();
        rst = 1'b0;
        chk_lvl("idle_out", 16'h0, 16'(idle_out));
        prog(0, SEL_NONE, 0, PORT_RAM0, PORT_EXT, AMOD_INC, AMOD_INC, 16'h10, 16'h100, 2, 1);
        wait_done();
        lat = 4'h3;
        prog(3, SEL_NONE, 0, PORT_RAM1, PORT_PERIPH, AMOD_DEC, AMOD_CONST, 0, 16'h8000, 3, 1);
        wait_done();
        for (int i = 0; i < NUM_EVT; i++)
        begin
            prog(i % NUM_CH, codes[i], 0, PORT_PERIPH, PORT_RAM0, AMOD_CONST, AMOD_INC,
                16'h40 + 16'(i), 16'h200 + 16'(i), 1, 1);
            pulse((i + 1) % NUM_EVT);
            quiet(10);
            pulse(i);
            wait_done();
        end
        prog(4, SEL_NONE, 1, PORT_EXT, PORT_RAM1, AMOD_INC, AMOD_INC, 16'h300, 16'h400, 2, 0);
        prog(1, SEL_NONE, 0, PORT_EXT, PORT_RAM0, AMOD_INC, AMOD_INC, 16'h310, 16'h410, 2, 0);
        tick();
        ch_enable = 6'h12;
        tick();
        ch_enable = '0;
        wait_done();
        idle_req = 1'b1;
        repeat (4) tick();
        chk_lvl("idle_out", 16'h1, 16'(idle_out));
        prog(2, SEL_NONE, 0, PORT_RAM0, PORT_RAM1, AMOD_INC, AMOD_INC, 16'h500, 16'h600, 2, 1);
        quiet(20);
        serial_wake = 1'b1;
        wait_done();
        repeat (4) tick();
        chk_lvl("idle_out", 16'h1, 16'(idle_out));
        {idle_req, serial_wake} = 2'h0;
        for (int k = 0; k < 4; k++)
        begin
            lat = 4'($random(seed));
            prog(5, SEL_NONE, 0, 2'($random(seed)), 2'($random(seed)), AMOD_INC, AMOD_DEC,
                16'($random(seed)), 16'($random(seed)), 16'(k + 1), 1);
            wait_done();
        end
        // Every event but the selected one: the channel must keep waiting
        prog(0, SEL_TIM1, 0, PORT_RAM0, PORT_RAM1, AMOD_INC, AMOD_INC, 16'h700, 16'h800, 1, 1);
        evt_in = ~(NUM_EVT'(1) << (EV_TIM0 + 1));
        repeat (3) tick();
        evt_in = '0;
        quiet(10);
        rst = 1'b1;
        tick();
        rst = 1'b0;
        wr_q.delete();
        irq_q.delete();
        tick();
        chk_lvl("ch_busy", 16'h0, 16'(ch_busy));
        report_and_stop();
    end
endmodule // test_des_engine
`default_nettype wire
